// ===== rtl/pmic_interrupt_mask_bank.sv
`timescale 1ns/1ns
// Summary of operation
// - pin 10 rising edge interrupt blocked when bit 4 set, passed when clear
// - pin 9 rising edge interrupt blocked when bit 3 set, passed when clear
// - pin 10 falling edge interrupt blocked when bit 1 set
// - pin 9 falling edge interrupt blocked when bit 0 set
// - pin edge masks never affect the live pin level status
// - soft reboot interrupt blocked by startup mask bit 5
// - first supply detection interrupt blocked by startup mask bit 4
// - enable input interrupt blocked by startup mask bit 1
// - thermal warning interrupt blocked by misc mask bit 3
// - external clock interrupt blocked by misc mask bit 1
// - self-test pass interrupt blocked by misc mask bit 0
// - reset output readback interrupt blocked by moderate mask bit 7
// - interrupt pin readback interrupt blocked by moderate mask bit 6
// - SPMI error interrupt blocked by moderate mask bit 4
// - config CRC error interrupt blocked by moderate mask bit 2
// - self-test fail interrupt blocked by moderate mask bit 1
// - masks reset to 0x00, then take defaults from non-volatile memory
module pmic_interrupt_mask_bank (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire pmic_mask_pkg::reg_req_t I_REG,
    output logic [7:0] O_REG_RDATA,
    input wire logic I_NVM_LOAD,
    input wire pmic_mask_pkg::masks_t I_NVM_DFLT,
    input wire logic [1:0] I_PIN,
    input wire pmic_mask_pkg::src_evt_t I_EVT,
    output pmic_mask_pkg::irq_t O_IRQ,
    output logic [1:0] O_PIN_LEVEL,
    output pmic_mask_pkg::masks_t O_MASKS
);

    pmic_mask_pkg::bank_t st;
    pmic_mask_pkg::bank_t next_st;
    logic [pmic_mask_pkg::NUM_PINS-1:0] rise;
    logic [pmic_mask_pkg::NUM_PINS-1:0] fall;
    logic [pmic_mask_pkg::NUM_PINS-1:0] level;

    // one synchroniser and edge finder per pin
    genvar g;
    generate
        for (g = 0; g < pmic_mask_pkg::NUM_PINS; g++) begin : g_pin
            pin_edge_sync u_sync (
                .i_clk(I_SYS_CLK),
                .i_rst_b(I_RST_B),
                .i_pin(I_PIN[g]),
                .o_level(level[g]),
                .o_rise(rise[g]),
                .o_fall(fall[g])
            );
        end
    endgenerate

    // read decode; unmapped offsets return zero
    function automatic logic [7:0] read_mux(
        input pmic_mask_pkg::masks_t m,
        input logic [7:0] addr
    );
        logic [7:0] d;
        d = 8'h00;
        case (addr)
            pmic_mask_pkg::ADDR_PIN_EDGE: d = m.pin_edge;
            pmic_mask_pkg::ADDR_STARTUP: d = m.startup;
            pmic_mask_pkg::ADDR_MISC: d = m.misc;
            pmic_mask_pkg::ADDR_MODERATE: d = m.moderate;
            pmic_mask_pkg::ADDR_SEQUENCER: d = m.sequencer;
            default: d = 8'h00;
        endcase
        return d;
    endfunction : read_mux

    // register writes, defaults load, read data and event gating
    always_comb begin
        next_st = st;
        if (I_REG.wr) begin
            case (I_REG.addr)
                pmic_mask_pkg::ADDR_PIN_EDGE: begin
                    next_st.masks.pin_edge =
                        I_REG.wdata & pmic_mask_pkg::RW_PIN_EDGE;
                end
                pmic_mask_pkg::ADDR_STARTUP: begin
                    next_st.masks.startup =
                        I_REG.wdata & pmic_mask_pkg::RW_STARTUP;
                end
                pmic_mask_pkg::ADDR_MISC: begin
                    next_st.masks.misc =
                        I_REG.wdata & pmic_mask_pkg::RW_MISC;
                end
                pmic_mask_pkg::ADDR_MODERATE: begin
                    next_st.masks.moderate =
                        I_REG.wdata & pmic_mask_pkg::RW_MODERATE;
                end
                pmic_mask_pkg::ADDR_SEQUENCER: begin
                    next_st.masks.sequencer =
                        I_REG.wdata & pmic_mask_pkg::RW_SEQUENCER;
                end
                default: begin
                end
            endcase
        end
        // defaults from non-volatile memory win over a write
        if (I_NVM_LOAD) begin
            next_st.masks.pin_edge =
                I_NVM_DFLT.pin_edge & pmic_mask_pkg::RW_PIN_EDGE;
            next_st.masks.startup =
                I_NVM_DFLT.startup & pmic_mask_pkg::RW_STARTUP;
            next_st.masks.misc = I_NVM_DFLT.misc & pmic_mask_pkg::RW_MISC;
            next_st.masks.moderate =
                I_NVM_DFLT.moderate & pmic_mask_pkg::RW_MODERATE;
            next_st.masks.sequencer =
                I_NVM_DFLT.sequencer & pmic_mask_pkg::RW_SEQUENCER;
        end
        if (I_REG.rd) begin
            next_st.rdata = read_mux(st.masks, I_REG.addr);
        end
        // pin edges: 1 blocks, 0 passes
        next_st.irq.pin10_rise = rise[pmic_mask_pkg::PIN10]
            & ~st.masks.pin_edge[pmic_mask_pkg::B_PIN10_RISE];
        next_st.irq.pin9_rise = rise[pmic_mask_pkg::PIN9]
            & ~st.masks.pin_edge[pmic_mask_pkg::B_PIN9_RISE];
        next_st.irq.pin10_fall = fall[pmic_mask_pkg::PIN10]
            & ~st.masks.pin_edge[pmic_mask_pkg::B_PIN10_FALL];
        next_st.irq.pin9_fall = fall[pmic_mask_pkg::PIN9]
            & ~st.masks.pin_edge[pmic_mask_pkg::B_PIN9_FALL];
        // startup events
        next_st.irq.src.soft_reboot = I_EVT.soft_reboot
            & ~st.masks.startup[pmic_mask_pkg::B_ITEM_A];
        next_st.irq.src.first_supply = I_EVT.first_supply
            & ~st.masks.startup[pmic_mask_pkg::B_FIRST_SUPPLY];
        next_st.irq.src.enable_evt = I_EVT.enable_evt
            & ~st.masks.startup[pmic_mask_pkg::B_ENABLE_EVT];
        // miscellaneous events
        next_st.irq.src.thermal_warn = I_EVT.thermal_warn
            & ~st.masks.misc[pmic_mask_pkg::B_THERMAL_WARN];
        next_st.irq.src.ext_clock = I_EVT.ext_clock
            & ~st.masks.misc[pmic_mask_pkg::B_EXT_CLOCK];
        next_st.irq.src.selftest_pass = I_EVT.selftest_pass
            & ~st.masks.misc[pmic_mask_pkg::B_SELFTEST_PASS];
        // moderate error events
        next_st.irq.src.rstout_rb = I_EVT.rstout_rb
            & ~st.masks.moderate[pmic_mask_pkg::B_RSTOUT_RB];
        next_st.irq.src.irq_pin_rb = I_EVT.irq_pin_rb
            & ~st.masks.moderate[pmic_mask_pkg::B_IRQ_PIN_RB];
        next_st.irq.src.spmi_err = I_EVT.spmi_err
            & ~st.masks.moderate[pmic_mask_pkg::B_SPMI_ERR];
        next_st.irq.src.cfg_crc_err = I_EVT.cfg_crc_err
            & ~st.masks.moderate[pmic_mask_pkg::B_CFG_CRC];
        next_st.irq.src.selftest_fail = I_EVT.selftest_fail
            & ~st.masks.moderate[pmic_mask_pkg::B_SELFTEST_FAIL];
    end

    // state register, documented reset values
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st.masks.pin_edge <= pmic_mask_pkg::RST_PIN_EDGE;
            st.masks.startup <= pmic_mask_pkg::RST_STARTUP;
            st.masks.misc <= pmic_mask_pkg::RST_MISC;
            st.masks.moderate <= pmic_mask_pkg::RST_MODERATE;
            st.masks.sequencer <= pmic_mask_pkg::RST_SEQUENCER;
            st.rdata <= 8'h00;
            st.irq <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops; level ignores every mask
    assign O_REG_RDATA = st.rdata;
    assign O_IRQ = st.irq;
    assign O_MASKS = st.masks;
    assign O_PIN_LEVEL = level;

    // checks on the gating, one clock domain
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_B);

    property p_pin10_rise;
        rise[pmic_mask_pkg::PIN10] |=> O_IRQ.pin10_rise ==
            !$past(st.masks.pin_edge[pmic_mask_pkg::B_PIN10_RISE]);
    endproperty
    a_pin10_rise: assert property (p_pin10_rise)
        else $error("pin 10 rise gating wrong");

    property p_pin9_rise;
        rise[pmic_mask_pkg::PIN9] |=> O_IRQ.pin9_rise ==
            !$past(st.masks.pin_edge[pmic_mask_pkg::B_PIN9_RISE]);
    endproperty
    a_pin9_rise: assert property (p_pin9_rise)
        else $error("pin 9 rise gating wrong");

    property p_pin10_fall;
        fall[pmic_mask_pkg::PIN10] |=> O_IRQ.pin10_fall ==
            !$past(st.masks.pin_edge[pmic_mask_pkg::B_PIN10_FALL]);
    endproperty
    a_pin10_fall: assert property (p_pin10_fall)
        else $error("pin 10 fall gating wrong");

    property p_pin9_fall;
        O_IRQ.pin9_fall |-> $past(fall[pmic_mask_pkg::PIN9])
            && !$past(st.masks.pin_edge[pmic_mask_pkg::B_PIN9_FALL]);
    endproperty
    a_pin9_fall: assert property (p_pin9_fall)
        else $error("pin 9 fall without cause");

    property p_level_high;
        I_PIN[pmic_mask_pkg::PIN9] [*7] |-> O_PIN_LEVEL[pmic_mask_pkg::PIN9];
    endproperty
    a_level_high: assert property (p_level_high)
        else $error("pin 9 level not tracking high");

    property p_level_low;
        !I_PIN[pmic_mask_pkg::PIN10] [*7] |->
            !O_PIN_LEVEL[pmic_mask_pkg::PIN10];
    endproperty
    a_level_low: assert property (p_level_low)
        else $error("pin 10 level not tracking low");

    property p_soft_reboot;
        I_EVT.soft_reboot && !st.masks.startup[pmic_mask_pkg::B_ITEM_A]
            |=> O_IRQ.src.soft_reboot;
    endproperty
    a_soft_reboot: assert property (p_soft_reboot)
        else $error("soft reboot event lost");

    property p_first_supply;
        O_IRQ.src.first_supply |-> $past(I_EVT.first_supply)
            && !$past(st.masks.startup[pmic_mask_pkg::B_FIRST_SUPPLY]);
    endproperty
    a_first_supply: assert property (p_first_supply)
        else $error("supply detect passed while masked");

    property p_enable_evt;
        I_EVT.enable_evt |=> O_IRQ.src.enable_evt ==
            !$past(st.masks.startup[pmic_mask_pkg::B_ENABLE_EVT]);
    endproperty
    a_enable_evt: assert property (p_enable_evt)
        else $error("enable event gating wrong");

    property p_thermal_warn;
        I_EVT.thermal_warn |=> O_IRQ.src.thermal_warn ==
            !$past(st.masks.misc[pmic_mask_pkg::B_THERMAL_WARN]);
    endproperty
    a_thermal_warn: assert property (p_thermal_warn)
        else $error("thermal warning gating wrong");

    property p_ext_clock;
        I_EVT.ext_clock |=> O_IRQ.src.ext_clock ==
            !$past(st.masks.misc[pmic_mask_pkg::B_EXT_CLOCK]);
    endproperty
    a_ext_clock: assert property (p_ext_clock)
        else $error("external clock gating wrong");

    property p_selftest_pass;
        O_IRQ.src.selftest_pass |-> $past(I_EVT.selftest_pass)
            && !$past(st.masks.misc[pmic_mask_pkg::B_SELFTEST_PASS]);
    endproperty
    a_selftest_pass: assert property (p_selftest_pass)
        else $error("self-test pass passed while masked");

    property p_rstout_rb;
        I_EVT.rstout_rb |=> O_IRQ.src.rstout_rb ==
            !$past(st.masks.moderate[pmic_mask_pkg::B_RSTOUT_RB]);
    endproperty
    a_rstout_rb: assert property (p_rstout_rb)
        else $error("reset readback gating wrong");

    property p_irq_pin_rb;
        I_EVT.irq_pin_rb |=> O_IRQ.src.irq_pin_rb ==
            !$past(st.masks.moderate[pmic_mask_pkg::B_IRQ_PIN_RB]);
    endproperty
    a_irq_pin_rb: assert property (p_irq_pin_rb)
        else $error("irq pin readback gating wrong");

    property p_spmi_err;
        I_EVT.spmi_err |=> O_IRQ.src.spmi_err ==
            !$past(st.masks.moderate[pmic_mask_pkg::B_SPMI_ERR]);
    endproperty
    a_spmi_err: assert property (p_spmi_err)
        else $error("link error gating wrong");

    property p_cfg_crc;
        O_IRQ.src.cfg_crc_err |-> $past(I_EVT.cfg_crc_err)
            && !$past(st.masks.moderate[pmic_mask_pkg::B_CFG_CRC]);
    endproperty
    a_cfg_crc: assert property (p_cfg_crc)
        else $error("crc error passed while masked");

    property p_selftest_fail;
        I_EVT.selftest_fail |=> O_IRQ.src.selftest_fail ==
            !$past(st.masks.moderate[pmic_mask_pkg::B_SELFTEST_FAIL]);
    endproperty
    a_selftest_fail: assert property (p_selftest_fail)
        else $error("self-test fail gating wrong");

    property p_reset_value;
        $rose(I_RST_B) |-> O_MASKS == '0;
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("masks not zero after reset");

    property p_nvm_load;
        I_NVM_LOAD |=> O_MASKS.startup ==
            ($past(I_NVM_DFLT.startup) & pmic_mask_pkg::RW_STARTUP)
            && O_MASKS.moderate ==
            ($past(I_NVM_DFLT.moderate) & pmic_mask_pkg::RW_MODERATE);
    endproperty
    a_nvm_load: assert property (p_nvm_load)
        else $error("defaults not loaded");

    property p_write_misc;
        I_REG.wr && !I_NVM_LOAD && I_REG.addr == pmic_mask_pkg::ADDR_MISC
            ##1 I_REG.rd && I_REG.addr == pmic_mask_pkg::ADDR_MISC
            |=> O_REG_RDATA == ($past(I_REG.wdata, 2)
            & pmic_mask_pkg::RW_MISC);
    endproperty
    a_write_misc: assert property (p_write_misc)
        else $error("misc write not read back");

    property p_masks_hold;
        !I_REG.wr && !I_NVM_LOAD |=> O_MASKS == $past(O_MASKS);
    endproperty
    a_masks_hold: assert property (p_masks_hold)
        else $error("masks changed without write or load");

    property p_reserved_zero;
        (O_MASKS.pin_edge & ~pmic_mask_pkg::RW_PIN_EDGE) == 8'h00
            && (O_MASKS.startup & ~pmic_mask_pkg::RW_STARTUP) == 8'h00
            && (O_MASKS.misc & ~pmic_mask_pkg::RW_MISC) == 8'h00
            && (O_MASKS.moderate & ~pmic_mask_pkg::RW_MODERATE) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved mask bit set");

    // main scenarios
    c_masked_edge: cover property (rise[pmic_mask_pkg::PIN10]
        && st.masks.pin_edge[pmic_mask_pkg::B_PIN10_RISE]);
    c_pass_edge: cover property (O_IRQ.pin9_fall);
    c_masked_err: cover property (I_EVT.spmi_err
        && st.masks.moderate[pmic_mask_pkg::B_SPMI_ERR]);
    c_nvm_then_irq: cover property (I_NVM_LOAD ##[1:20] O_IRQ.src.enable_evt);
    c_load_and_write: cover property (I_NVM_LOAD && I_REG.wr);

endmodule : pmic_interrupt_mask_bank

// ===== rtl/pmic_mask_pkg.sv
package pmic_mask_pkg;

    // register offsets
    localparam logic [7:0] ADDR_PIN_EDGE = 8'h51;
    localparam logic [7:0] ADDR_STARTUP = 8'h52;
    localparam logic [7:0] ADDR_MISC = 8'h53;
    localparam logic [7:0] ADDR_MODERATE = 8'h54;
    localparam logic [7:0] ADDR_SEQUENCER = 8'h56;

    // reset values of the mask registers
    localparam logic [7:0] RST_PIN_EDGE = 8'h00;
    localparam logic [7:0] RST_STARTUP = 8'h00;
    localparam logic [7:0] RST_MISC = 8'h00;
    localparam logic [7:0] RST_MODERATE = 8'h00;
    localparam logic [7:0] RST_SEQUENCER = 8'h00;

    // bits that hold a mask; reserved bits read zero
    localparam logic [7:0] RW_PIN_EDGE = 8'h1B;
    localparam logic [7:0] RW_STARTUP = 8'h32;
    localparam logic [7:0] RW_MISC = 8'h0B;
    localparam logic [7:0] RW_MODERATE = 8'hD6;
    localparam logic [7:0] RW_SEQUENCER = 8'hFF;

    // field positions, pin edge register
    localparam int B_PIN9_FALL = 0;
    localparam int B_PIN10_FALL = 1;
    localparam int B_PIN9_RISE = 3;
    localparam int B_PIN10_RISE = 4;
    // field positions, startup register
    localparam int B_ENABLE_EVT = 1;
    localparam int B_FIRST_SUPPLY = 4;
    localparam int B_ITEM_A = 5;
    // field positions, misc register
    localparam int B_SELFTEST_PASS = 0;
    localparam int B_EXT_CLOCK = 1;
    localparam int B_THERMAL_WARN = 3;
    // field positions, moderate error register
    localparam int B_SELFTEST_FAIL = 1;
    localparam int B_CFG_CRC = 2;
    localparam int B_SPMI_ERR = 4;
    localparam int B_IRQ_PIN_RB = 6;
    localparam int B_RSTOUT_RB = 7;

    // pin indices and synchroniser depth
    localparam int NUM_PINS = 2;
    localparam int PIN9 = 0;
    localparam int PIN10 = 1;
    localparam logic [2:0] SYNC_FILL = 3'h3;
    localparam logic [2:0] SYNC_SETTLED = 3'h4;

    typedef struct packed {
        logic [7:0] pin_edge;
        logic [7:0] startup;
        logic [7:0] misc;
        logic [7:0] moderate;
        logic [7:0] sequencer;
    } masks_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic soft_reboot;
        logic first_supply;
        logic enable_evt;
        logic thermal_warn;
        logic ext_clock;
        logic selftest_pass;
        logic rstout_rb;
        logic irq_pin_rb;
        logic spmi_err;
        logic cfg_crc_err;
        logic selftest_fail;
    } src_evt_t;

    typedef struct packed {
        logic pin10_rise;
        logic pin9_rise;
        logic pin10_fall;
        logic pin9_fall;
        src_evt_t src;
    } irq_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [2:0] fill;
        logic level;
        logic rise;
        logic fall;
    } sync_t;

    typedef struct packed {
        masks_t masks;
        logic [7:0] rdata;
        irq_t irq;
    } bank_t;

endpackage : pmic_mask_pkg

// ===== rtl/pin_edge_sync.sv
`timescale 1ns/1ns
module pin_edge_sync (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);

    pmic_mask_pkg::sync_t st;
    pmic_mask_pkg::sync_t next_st;

    // three-stage sync; level moves once stages two and three agree
    always_comb begin
        next_st = st;
        next_st.s1 = i_pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.rise = 1'b0;
        next_st.fall = 1'b0;
        // count the fill; settled code marks the first level taken
        if (st.fill < pmic_mask_pkg::SYNC_FILL) begin
            next_st.fill = st.fill + 3'h1;
        end
        if (st.fill >= pmic_mask_pkg::SYNC_FILL && (st.s2 == st.s3)) begin
            next_st.level = st.s3;
            next_st.fill = pmic_mask_pkg::SYNC_SETTLED;
            // no edge on the very first settle after reset
            if (st.fill == pmic_mask_pkg::SYNC_SETTLED
                && st.s3 != st.level) begin
                next_st.rise = st.s3;
                next_st.fall = ~st.s3;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_level = st.level;
    assign o_rise = st.rise;
    assign o_fall = st.fall;

endmodule : pin_edge_sync

// ===== bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    // writable bits of every register, in struct order
    localparam pmic_mask_pkg::masks_t RW_ALL = {pmic_mask_pkg::RW_PIN_EDGE,
        pmic_mask_pkg::RW_STARTUP, pmic_mask_pkg::RW_MISC,
        pmic_mask_pkg::RW_MODERATE, pmic_mask_pkg::RW_SEQUENCER};

    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    pmic_mask_pkg::reg_req_t reg_req = '0;
    logic nvm_load = 1'b0;
    pmic_mask_pkg::masks_t nvm_dflt = '0;
    logic [1:0] pin = 2'h0;
    pmic_mask_pkg::src_evt_t evt = '0;
    logic [7:0] rdata;
    pmic_mask_pkg::irq_t irq;
    logic [1:0] pin_level;
    pmic_mask_pkg::masks_t masks;
    pmic_mask_pkg::masks_t mdl = '0;
    logic [7:0] exp_rd = 8'h00;
    logic [31:0] r1;
    logic [31:0] r2;
    logic [31:0] r3;
    int n_errors = 0;
    int n_tests = 0;
    // five mapped offsets followed by three unmapped ones
    logic [7:0] addr_tab [8] = '{8'h51, 8'h52, 8'h53, 8'h54, 8'h56,
                                 8'h55, 8'h57, 8'h50};

    // 10 MHz system clock
    always #50 sys_clk = ~sys_clk;

    pmic_interrupt_mask_bank u_dut (
        .I_SYS_CLK(sys_clk),
        .I_RST_B(rst_b),
        .I_REG(reg_req),
        .O_REG_RDATA(rdata),
        .I_NVM_LOAD(nvm_load),
        .I_NVM_DFLT(nvm_dflt),
        .I_PIN(pin),
        .I_EVT(evt),
        .O_IRQ(irq),
        .O_PIN_LEVEL(pin_level),
        .O_MASKS(masks)
    );

    // register contents as seen by a read
    function automatic logic [7:0] rd_model(input pmic_mask_pkg::masks_t m,
                                            input logic [7:0] a);
        case (a)
            pmic_mask_pkg::ADDR_PIN_EDGE: return m.pin_edge;
            pmic_mask_pkg::ADDR_STARTUP: return m.startup;
            pmic_mask_pkg::ADDR_MISC: return m.misc;
            pmic_mask_pkg::ADDR_MODERATE: return m.moderate;
            pmic_mask_pkg::ADDR_SEQUENCER: return m.sequencer;
            default: return 8'h00;
        endcase
    endfunction : rd_model

    // write effect; reserved bits and unmapped offsets drop data
    function automatic pmic_mask_pkg::masks_t wr_model(
        input pmic_mask_pkg::masks_t m, input logic [7:0] a,
        input logic [7:0] d);
        pmic_mask_pkg::masks_t n;
        n = {d, d, d, d, d} & RW_ALL;
        case (a)
            pmic_mask_pkg::ADDR_PIN_EDGE: m.pin_edge = n.pin_edge;
            pmic_mask_pkg::ADDR_STARTUP: m.startup = n.startup;
            pmic_mask_pkg::ADDR_MISC: m.misc = n.misc;
            pmic_mask_pkg::ADDR_MODERATE: m.moderate = n.moderate;
            pmic_mask_pkg::ADDR_SEQUENCER: m.sequencer = n.sequencer;
            default: ;
        endcase
        return m;
    endfunction : wr_model

    // mask bit that blocks each event source
    function automatic pmic_mask_pkg::src_evt_t src_mask(
        input pmic_mask_pkg::masks_t m);
        pmic_mask_pkg::src_evt_t s;
        s.soft_reboot = m.startup[pmic_mask_pkg::B_ITEM_A];
        s.first_supply = m.startup[pmic_mask_pkg::B_FIRST_SUPPLY];
        s.enable_evt = m.startup[pmic_mask_pkg::B_ENABLE_EVT];
        s.thermal_warn = m.misc[pmic_mask_pkg::B_THERMAL_WARN];
        s.ext_clock = m.misc[pmic_mask_pkg::B_EXT_CLOCK];
        s.selftest_pass = m.misc[pmic_mask_pkg::B_SELFTEST_PASS];
        s.rstout_rb = m.moderate[pmic_mask_pkg::B_RSTOUT_RB];
        s.irq_pin_rb = m.moderate[pmic_mask_pkg::B_IRQ_PIN_RB];
        s.spmi_err = m.moderate[pmic_mask_pkg::B_SPMI_ERR];
        s.cfg_crc_err = m.moderate[pmic_mask_pkg::B_CFG_CRC];
        s.selftest_fail = m.moderate[pmic_mask_pkg::B_SELFTEST_FAIL];
        return s;
    endfunction : src_mask

    // compare and count
    task automatic check(input string what, input logic [39:0] seen,
                         input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    // one clock of stimulus, then compare event irqs, masks and read data with the model
    task automatic cyc(input logic rd, input logic wr, input logic [7:0] a,
                       input logic [7:0] d, input logic ld,
                       input logic [10:0] e);
        pmic_mask_pkg::src_evt_t exp_irq;
        reg_req = {rd, wr, a, d};
        nvm_load = ld;
        evt = e;
        exp_irq = e & ~src_mask(mdl);
        if (rd) exp_rd = rd_model(mdl, a);
        if (ld) mdl = nvm_dflt & RW_ALL;
        else if (wr) mdl = wr_model(mdl, a, d);
        @(negedge sys_clk);
        check("startup irq", irq.src[10:8], exp_irq[10:8]);
        check("misc irq", irq.src[7:5], exp_irq[7:5]);
        check("error irq", irq.src[4:2], exp_irq[4:2]);
        check("crc fail irq", irq.src[1:0], exp_irq[1:0]);
        check("masks", masks, mdl);
        check("read data", rdata, exp_rd);
    endtask : cyc

    // one pin edge under a mask that hides it or only its neighbours
    task automatic pin_case(input int idx, input logic val, input logic hide);
        int bpos;
        logic [7:0] bit1;
        logic [3:0] want;
        logic [3:0] seen;
        bpos = val ? (idx ? pmic_mask_pkg::B_PIN10_RISE
                          : pmic_mask_pkg::B_PIN9_RISE)
                   : (idx ? pmic_mask_pkg::B_PIN10_FALL
                          : pmic_mask_pkg::B_PIN9_FALL);
        bit1 = 8'h01 << bpos;
        want = val ? (idx ? 4'h8 : 4'h4) : (idx ? 4'h2 : 4'h1);
        cyc(1'b0, 1'b1, pmic_mask_pkg::ADDR_PIN_EDGE,
            hide ? bit1 : (pmic_mask_pkg::RW_PIN_EDGE & ~bit1), 1'b0, 11'h000);
        pin[idx] = val;
        seen = 4'h0;
        repeat (8) begin
            cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 11'h000);
            seen = seen | {irq.pin10_rise, irq.pin9_rise,
                           irq.pin10_fall, irq.pin9_fall};
        end
        check("pin irq", seen, hide ? 4'h0 : want);
        check("pin level", pin_level, pin);
    endtask : pin_case

    // verdict and end of run
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    // watchdog far beyond the expected run of about nine hundred cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        $display("unexpected watchdog expiry");
        complete_run();
    end

    // main sequence
    initial begin
        void'($urandom(60223));
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        @(negedge sys_clk);
        // reset values, unmapped reads
        foreach (addr_tab[i])
            cyc(1'b1, 1'b0, addr_tab[i], 8'h00, 1'b0, 11'h000);
        // all ones written; same-cycle read returns the old value
        foreach (addr_tab[i])
            cyc(1'b1, 1'b1, addr_tab[i], 8'hFF, 1'b0, 11'h7FF);
        foreach (addr_tab[i])
            cyc(1'b1, 1'b0, addr_tab[i], 8'h00, 1'b0, 11'h7FF);
        // default load beats a write in the same cycle
        nvm_dflt = 40'hA5C35A3C96;
        cyc(1'b1, 1'b1, pmic_mask_pkg::ADDR_MISC, 8'hFF, 1'b1, 11'h7FF);
        cyc(1'b1, 1'b0, pmic_mask_pkg::ADDR_MISC, 8'h00, 1'b0, 11'h7FF);
        // random traffic, back to back
        repeat (800) begin
            r1 = $urandom;
            r2 = $urandom;
            r3 = $urandom;
            nvm_dflt = {r1, r3[31:24]};
            cyc(r2[0], r2[1], addr_tab[r2[4:2]], r2[12:5], r2[17:13] == 5'h00,
                r3[10:0]);
        end
        // pin edges, masked then unmasked
        for (int idx = 0; idx < 2; idx++) begin
            for (int k = 0; k < 4; k++) pin_case(idx, ~k[0], k < 2);
        end
        // reset in mid-run clears every mask
        cyc(1'b0, 1'b1, pmic_mask_pkg::ADDR_SEQUENCER, 8'h5A, 1'b0, 11'h000);
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 11'h000);
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        check("masks in reset", masks, 40'h0000000000);
        mdl = '0;
        exp_rd = 8'h00;
        rst_b = 1'b1;
        @(negedge sys_clk);
        foreach (addr_tab[i])
            cyc(1'b1, 1'b0, addr_tab[i], 8'h00, 1'b0, 11'h7FF);
        complete_run();
    end
endmodule : testbench
